/* bench/io_node.sv */
// edge I/O node model that drains the tile and returns messages
`default_nettype none
module io_node (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench commands
  input wire logic hold_off,
  input wire logic msg_go,
  input wire logic [3:0] msg_usr,
  input wire logic msg_partner,
  // words from the tile
  input wire logic net_out_valid,
  output logic net_out_ready,
  input wire logic [31:0] net_out_data,
  // words toward the tile
  output logic net_in_valid,
  input wire logic net_in_ready,
  output logic [31:0] net_in_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // drains unless the bench raises hold_off
  // unbounded sink stands for the per-tile reserve and spare pool
  assign net_out_ready = !hold_off;
  always @(posedge clk) begin
    if (rst) begin
      net_in_valid <= 1'b0;
      net_in_data <= 32'h0;
    end else if (net_in_valid && net_in_ready) begin
      net_in_valid <= 1'b0;
      // released line shows the inverse, never a stale copy
      net_in_data <= ~net_in_data;
    end else if (msg_go) begin
      net_in_valid <= 1'b1;
      net_in_data <= {3'h0, 5'h00, msg_usr, msg_partner, 19'h00000};
    end
  end
endmodule // io_node
`default_nettype wire

/* bench/memory_net_meter_tb.sv */
// self-checking bench for the memory network meter
`include "meter_defines.vh"
`default_nettype none
module memory_net_meter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 400;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic cache_txn_valid = 1'b0;
  logic cache_txn_store = 1'b0;
  logic cache_txn_partner = 1'b0;
  logic [`HDR_DEST_HI:0] cache_txn_dest = 19'h00123;
  logic [31:0] cache_txn_addr = 32'h0;
  logic cache_word_valid = 1'b0;
  logic [31:0] cache_word_data = 32'h0;
  logic hold_off = 1'b0;
  logic msg_go = 1'b0;
  logic [3:0] msg_usr = 4'h0;
  logic msg_partner = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, net_out_data, net_in_data, rx_data;
  logic cache_txn_ready, cache_stalled, cache_word_ready, net_out_valid, net_out_ready;
  logic net_in_valid, net_in_ready, rx_valid;
  int miscompares = 0;
  int n_checks = 0;
  int rx_count = 0;
  logic [31:0] seen[$];
  logic [31:0] rd;
  logic [1:0] rsp;

  memory_net_meter u_dut (.*);
  io_node u_io (.*);

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (net_out_valid === 1'b1 && net_out_ready === 1'b1) begin
      seen.push_back(net_out_data);
    end
    if (rx_valid === 1'b1) begin
      rx_count <= rx_count + 1;
    end
  end

  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic expect32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up(input logic ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t wait ran out", $time);
      complete_run();
    end
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    int n;
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < LIMIT && !(aw_ok && w_ok); n++) begin
      @(negedge clk);
      aw_ok = aw_ok | (s_axi_awready === 1'b1);
      w_ok = w_ok | (s_axi_wready === 1'b1);
      @(posedge clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    give_up(aw_ok & w_ok);
    for (n = 0; n < LIMIT && s_axi_bvalid !== 1'b1; n++) @(negedge clk);
    give_up(s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    expect32(32'(rsp), 32'(`RESP_OKAY), "write response");
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp, input string what);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge clk);
    for (n = 0; n < LIMIT && s_axi_arready !== 1'b1; n++) @(negedge clk);
    give_up(s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < LIMIT && s_axi_rvalid !== 1'b1; n++) @(negedge clk);
    give_up(s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    expect32(32'(rsp), 32'(`RESP_OKAY), "read response");
    if (exp !== 32'hFFFF_FFFF) expect32(rd, exp, what);
  endtask

  task automatic txn(input logic st, input logic pt, input logic [31:0] ad, input logic wt);
    int n;
    @(posedge clk);
    cache_txn_valid <= 1'b1;
    cache_txn_store <= st;
    cache_txn_partner <= pt;
    cache_txn_addr <= ad;
    if (wt) begin
      @(negedge clk);
      for (n = 0; n < LIMIT && cache_txn_ready !== 1'b1; n++) @(negedge clk);
      give_up(cache_txn_ready);
      @(posedge clk);
      cache_txn_valid <= 1'b0;
    end
  endtask

  task automatic feed_line();
    int i;
    int n;
    for (i = 0; i < 8; i++) begin
      cache_word_valid <= 1'b1;
      cache_word_data <= 32'hD000_0000 + 32'(i);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (cache_word_ready !== 1'b1 && n < LIMIT);
      give_up(cache_word_ready);
      @(posedge clk);
    end
    cache_word_valid <= 1'b0;
  endtask

  task automatic wait_words(input int cnt);
    int n;
    for (n = 0; n < LIMIT && seen.size() < cnt; n++) @(negedge clk);
    give_up(seen.size() >= cnt);
  endtask

  task automatic send_msg(input logic [3:0] usr, input logic p);
    @(posedge clk);
    msg_usr <= usr;
    msg_partner <= p;
    msg_go <= 1'b1;
    @(posedge clk);
    msg_go <= 1'b0;
  endtask

  task automatic t_reset_values();
    chk_reg(`REG_CREDITS, 32'h0008_0001, "credits after reset");
    chk_reg(`REG_STORE_ACK, 32'h0, "ack register reads zero");
    chk_reg(`REG_STATUS, 32'h0, "status after reset");
  endtask

  task automatic t_read_txn();
    seen.delete();
    txn(1'b0, 1'b1, 32'h0000_1240, 1'b1);
    wait_words(2);
    expect32(32'({seen[0][28:20], seen[0][18:0]}), 32'({`LEN_READ, `USR_LINE_READ, cache_txn_dest}), "read header");
    expect32(seen[1], 32'h0000_1240, "read address");
    chk_reg(`REG_CREDITS, 32'h0008_0001, "reads use no credit");
  endtask

  task automatic t_store_stall();
    seen.delete();
    txn(1'b1, 1'b0, 32'h0000_2000, 1'b1);
    feed_line();
    wait_words(10);
    expect32(32'({seen[0][28:20], seen[0][18:0]}), 32'({`LEN_WRITE, `USR_LINE_WRITE, cache_txn_dest}), "line write header");
    expect32(seen[9], 32'hD000_0007, "last line word");
    chk_reg(`REG_CREDITS, 32'h0008_0000, "store took a credit");
    txn(1'b0, 1'b1, 32'h0000_3000, 1'b0);
    chk_reg(`REG_STATUS, 32'hFFFF_FFFF, "");
    expect32(32'(rd[3:0]), 32'h4, "stalled and idle");
    expect32(32'({cache_stalled, cache_txn_ready}), 32'h2, "no take while empty");
    send_msg(`USR_STORE_ACK, 1'b0);
    txn(1'b0, 1'b1, 32'h0000_3000, 1'b1);
    chk_reg(`REG_CREDITS, 32'h0008_0001, "reply restored credit");
  endtask

  task automatic t_borrow();
    chk_reg(`REG_CREDITS, 32'h0008_0001, "credits before borrow");
    axi_write(`REG_STORE_ACK, 32'h0000_0002);
    chk_reg(`REG_CREDITS, 32'h0008_0001, "no borrow without flag");
    axi_write(`REG_STORE_ACK, 32'h0000_0003);
    chk_reg(`REG_CREDITS, 32'h0007_0001, "partner credit borrowed");
    axi_write(`REG_STORE_ACK, 32'h0000_0001);
    chk_reg(`REG_CREDITS, 32'h0007_0000, "other credit borrowed");
    send_msg(`USR_STORE_ACK, 1'b1);
    send_msg(`USR_STORE_ACK, 1'b0);
    chk_reg(`REG_CREDITS, 32'h0008_0001, "replies returned credits");
    expect32(32'(rx_count), 32'h0, "acks not forwarded");
    // borrow and reply both land on the same edge
    fork
      axi_write(`REG_STORE_ACK, 32'h0000_0003);
      send_msg(`USR_STORE_ACK, 1'b1);
    join
    chk_reg(`REG_CREDITS, 32'h0008_0001, "borrow and reply cancel");
    send_msg(`USR_LINE_READ, 1'b1);
    chk_reg(`REG_CREDITS, 32'h0008_0001, "plain reply leaves credits");
    expect32(32'(rx_count), 32'h1, "plain reply forwarded");
    expect32(rx_data, 32'h0008_0000, "forwarded reply word");
  endtask

  task automatic t_queue_fill();
    int i;
    @(posedge clk);
    hold_off <= 1'b1;
    seen.delete();
    for (i = 0; i < 16; i++) axi_write(`REG_SEND, 32'hA000_0000 + 32'(i));
    chk_reg(`REG_STATUS, 32'h0000_1000, "queue holds sixteen");
    axi_write(`REG_SEND, 32'hA000_0010);
    chk_reg(`REG_STATUS, 32'h0000_1008, "full queue drops word");
    @(posedge clk);
    hold_off <= 1'b0;
    wait_words(16);
    expect32(seen[15], 32'hA000_000F, "drain order");
    chk_reg(`REG_STATUS, 32'h0000_0008, "drained, drop sticky");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_read_txn();
    t_store_stall();
    t_borrow();
    t_queue_fill();
    complete_run();
  end
endmodule // memory_net_meter_tb
`default_nettype wire

/* bench/net_meter_sva.sv */
// port assertions for the memory network meter
`default_nettype none
module net_meter_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // cache and network
  input wire logic cache_txn_valid,
  input wire logic cache_txn_ready,
  input wire logic cache_txn_store,
  input wire logic cache_stalled,
  input wire logic net_out_valid,
  input wire logic net_out_ready,
  input wire logic [31:0] net_out_data,
  input wire logic net_in_valid,
  input wire logic net_in_ready,
  input wire logic rx_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_take;
    cache_txn_valid && cache_txn_ready && !cache_txn_store;
  endsequence
  chk_in_sink: assert property (net_in_ready)
    else $error("incoming word refused");
  chk_stall_blocks: assert property (cache_stalled |-> cache_txn_valid && !cache_txn_ready)
    else $error("stalled transaction was taken");
  chk_stall_holds: assert property (cache_stalled && !net_in_valid |=> cache_stalled)
    else $error("stall ended with no reply");
  chk_out_hold: assert property (net_out_valid && !net_out_ready
    |=> net_out_valid && $stable(net_out_data))
    else $error("queue head moved while blocked");
  chk_rx_cause: assert property (rx_valid |-> $past(net_in_valid))
    else $error("forwarded word with no arrival");
  chk_write_reply: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_read_reply: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_read_header: assert property (read_take |-> ##[1:3] net_out_valid)
    else $error("read request never sent");
endmodule // net_meter_sva
bind memory_net_meter net_meter_sva u_sva (.*);
`default_nettype wire

/* hw/memory_net_meter.v */
// tile memory network sender with buffer metering and AXI4-Lite registers
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`include "meter_defines.vh"
`default_nettype none
module memory_net_meter #(
  parameter QUEUE_DEPTH = 16,
  parameter CW = 8,
  parameter [CW-1:0] PARTNER_CREDITS = 8'h08,
  parameter [CW-1:0] NONPARTNER_CREDITS = 8'h01
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // cache transaction request
  input wire cache_txn_valid,
  output wire cache_txn_ready,
  input wire cache_txn_store,
  input wire cache_txn_partner,
  input wire [`HDR_DEST_HI:0] cache_txn_dest,
  input wire [31:0] cache_txn_addr,
  output wire cache_stalled,
  // cache line data for stores
  input wire cache_word_valid,
  output wire cache_word_ready,
  input wire [31:0] cache_word_data,
  // outgoing memory_dynamic_network words
  output wire net_out_valid,
  input wire net_out_ready,
  output wire [31:0] net_out_data,
  // incoming memory_dynamic_network words
  input wire net_in_valid,
  output wire net_in_ready,
  input wire [31:0] net_in_data,
  // replies passed on to the cache
  output wire rx_valid,
  output wire [31:0] rx_data
);
  localparam LW = $clog2(QUEUE_DEPTH+1);

  // write channel state
  reg aw_full_r;
  reg [3:0] aw_addr_r;
  reg w_full_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  // read channel state
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  // sender state
  reg [1:0] state_r;
  reg store_r;
  reg partner_r;
  reg [`HDR_DEST_HI:0] dest_r;
  reg [31:0] addr_r;
  reg [3:0] words_r;
  reg send_drop_r;
  // receive state
  reg [4:0] remain_r;
  reg rx_valid_r;
  reg [31:0] rx_data_r;

  wire wr_do;
  wire rd_do;
  wire wr_hit;
  wire wr_ok;
  wire borrow_p;
  wire borrow_np;
  wire [CW-1:0] cnt_p;
  wire [CW-1:0] cnt_np;
  wire zero_p;
  wire zero_np;
  wire txn_take;
  wire sw_push;
  wire ack_p;
  wire ack_np;
  wire is_hdr;
  wire is_ack;
  wire [LW-1:0] q_level;
  reg q_valid;
  reg [31:0] q_data;
  wire q_ready;

  function reg_known;
    input [3:0] a;
    begin
      reg_known = (a == `REG_STORE_ACK) || (a == `REG_CREDITS) ||
        (a == `REG_STATUS) || (a == `REG_SEND);
    end
  endfunction

  function [31:0] make_hdr;
    input [4:0] len;
    input [3:0] usr;
    input [`HDR_DEST_HI:0] dest;
    begin
      make_hdr = 32'h0;
      make_hdr[`HDR_LEN_HI:`HDR_LEN_LO] = len;
      make_hdr[`HDR_USR_HI:`HDR_USR_LO] = usr;
      make_hdr[`HDR_DEST_HI:0] = dest;
    end
  endfunction

  // write address and data may arrive in either order
  assign s_axi_awready = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready = ~w_full_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign wr_do = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_hit = reg_known(aw_addr_r);
  assign wr_ok = wr_do & wr_hit & w_strb_r[0];

  always @(posedge clk) begin
    if (rst) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_full_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign borrow_p = wr_ok && (aw_addr_r == `REG_STORE_ACK) &&
    w_data_r[`ACK_BORROW_BIT] && w_data_r[`ACK_PARTNER_BIT];
  assign borrow_np = wr_ok && (aw_addr_r == `REG_STORE_ACK) &&
    w_data_r[`ACK_BORROW_BIT] && !w_data_r[`ACK_PARTNER_BIT];
  // software word into the outgoing queue, only while the cache is idle
  assign sw_push = wr_ok && (aw_addr_r == `REG_SEND);

  // read channel, answer one cycle after the address
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rd_do = s_axi_arvalid & ~rvalid_r;

  always @(posedge clk) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `RESP_OKAY;
    end else if (rd_do) begin
      rvalid_r <= 1'b1;
      rresp_r <= reg_known({s_axi_araddr[3:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_r <= 32'h0;
      case ({s_axi_araddr[3:2], 2'b00})
        `REG_CREDITS: begin
          rdata_r[`CRD_NP_LO +: CW] <= cnt_np;
          rdata_r[`CRD_P_LO +: CW] <= cnt_p;
        end
        `REG_STATUS: begin
          rdata_r[`STS_STATE_HI:0] <= state_r;
          rdata_r[`STS_STALL_BIT] <= cache_stalled;
          rdata_r[`STS_DROP_BIT] <= send_drop_r;
          rdata_r[`STS_LEVEL_LO +: LW] <= q_level;
        end
        default: begin
          rdata_r <= 32'h0;
        end
      endcase
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign cache_stalled = cache_txn_valid & (state_r == `ST_IDLE) & (zero_p | zero_np);
  // hold the transaction until a reply
  assign txn_take = cache_txn_valid & (state_r == `ST_IDLE) & ~zero_p & ~zero_np;
  assign cache_txn_ready = txn_take;
  assign cache_word_ready = (state_r == `ST_DATA) & q_ready;

  // sender multiplexer into the queue
  always @* begin
    q_valid = 1'b0;
    q_data = 32'h0;
    case (state_r)
      `ST_IDLE: begin
        q_valid = sw_push;
        q_data = w_data_r;
      end
      // line read or write header, address, then eight words for a write only
      `ST_HDR: begin
        q_valid = 1'b1;
        q_data = store_r ? make_hdr(`LEN_WRITE, `USR_LINE_WRITE, dest_r) :
          make_hdr(`LEN_READ, `USR_LINE_READ, dest_r);
      end
      `ST_ADDR: begin
        q_valid = 1'b1;
        q_data = addr_r;
      end
      `ST_DATA: begin
        q_valid = cache_word_valid;
        q_data = cache_word_data;
      end
      default: begin
        q_valid = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= `ST_IDLE;
      store_r <= 1'b0;
      partner_r <= 1'b0;
      dest_r <= {(`HDR_DEST_HI+1){1'b0}};
      addr_r <= 32'h0;
      words_r <= 4'h0;
      send_drop_r <= 1'b0;
    end else begin
      // a software word that finds the queue busy or full is lost and flagged
      if (sw_push & ~((state_r == `ST_IDLE) & q_ready)) begin
        send_drop_r <= 1'b1;
      end
      case (state_r)
        `ST_IDLE: begin
          if (txn_take) begin
            store_r <= cache_txn_store;
            partner_r <= cache_txn_partner;
            dest_r <= cache_txn_dest;
            addr_r <= cache_txn_addr;
            words_r <= 4'h0;
            state_r <= `ST_HDR;
          end
        end
        `ST_HDR: begin
          if (q_ready) begin
            state_r <= `ST_ADDR;
          end
        end
        `ST_ADDR: begin
          if (q_ready) begin
            state_r <= store_r ? `ST_DATA : `ST_IDLE;
          end
        end
        `ST_DATA: begin
          if (cache_word_valid & q_ready) begin
            words_r <= words_r + 1'b1;
            if (words_r == `LINE_WORDS - 1'b1) begin
              state_r <= `ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= `ST_IDLE;
        end
      endcase
    end
  end

  word_fifo #(
    .WIDTH(32),
    .DEPTH(QUEUE_DEPTH)
  ) out_queue (
    .clk(clk),
    .rst(rst),
    .in_valid(q_valid),
    .in_ready(q_ready),
    .in_data(q_data),
    .out_valid(net_out_valid),
    .out_ready(net_out_ready),
    .out_data(net_out_data),
    .level(q_level)
  );

  assign net_in_ready = 1'b1;
  assign is_hdr = net_in_valid & (remain_r == 5'h00);
  // ack code and sender select counter
  assign is_ack = is_hdr & (net_in_data[`HDR_USR_HI:`HDR_USR_LO] == `USR_STORE_ACK);
  assign ack_p = is_ack & net_in_data[`HDR_SENDER_BIT];
  assign ack_np = is_ack & ~net_in_data[`HDR_SENDER_BIT];

  always @(posedge clk) begin
    if (rst) begin
      remain_r <= 5'h00;
      rx_valid_r <= 1'b0;
      rx_data_r <= 32'h0;
    end else begin
      rx_valid_r <= net_in_valid & ~is_ack;
      if (net_in_valid) begin
        rx_data_r <= net_in_data;
        remain_r <= is_hdr ? net_in_data[`HDR_LEN_HI:`HDR_LEN_LO] : remain_r - 1'b1;
      end
    end
  end
  assign rx_valid = rx_valid_r;
  assign rx_data = rx_data_r;

  store_credit #(
    .WIDTH(CW),
    .INIT(PARTNER_CREDITS)
  ) partner_credit (
    .clk(clk),
    .rst(rst),
    .issue_dec(txn_take & cache_txn_store & cache_txn_partner),
    .borrow_dec(borrow_p),
    .reply_inc(ack_p),
    .count(cnt_p),
    .zero(zero_p)
  );

  store_credit #(
    .WIDTH(CW),
    .INIT(NONPARTNER_CREDITS)
  ) other_credit (
    .clk(clk),
    .rst(rst),
    .issue_dec(txn_take & cache_txn_store & ~cache_txn_partner),
    .borrow_dec(borrow_np),
    .reply_inc(ack_np),
    .count(cnt_np),
    .zero(zero_np)
  );
endmodule // memory_net_meter
`default_nettype wire

/* hw/store_credit.v */
// one outstanding-store credit counter
`default_nettype none
module store_credit #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] INIT = 8'h04
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // updates
  input wire issue_dec,
  input wire borrow_dec,
  input wire reply_inc,
  // state
  output wire [WIDTH-1:0] count,
  output wire zero
);
  reg [WIDTH-1:0] count_r;
  reg [WIDTH-1:0] count_nxt;
  reg [1:0] decs;

  assign count = count_r;
  assign zero = (count_r == {WIDTH{1'b0}});

  always @* begin
    decs = {1'b0, issue_dec} + {1'b0, borrow_dec};
    count_nxt = count_r + {{(WIDTH-1){1'b0}}, reply_inc};
    // never wrap below zero if software borrows wrongly
    if (count_nxt >= {{(WIDTH-2){1'b0}}, decs}) begin
      count_nxt = count_nxt - {{(WIDTH-2){1'b0}}, decs};
    end else begin
      count_nxt = {WIDTH{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      count_r <= INIT;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule // store_credit
`default_nettype wire

/* hw/word_fifo.v */
// synchronous valid/ready FIFO with parameter width and depth
`default_nettype none
module word_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // occupancy
  output wire [$clog2(DEPTH+1)-1:0] level
);
  localparam AW = $clog2(DEPTH);
  localparam CW = $clog2(DEPTH+1);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [CW-1:0] count_r;
  wire push;
  wire pop;

  assign in_ready = (count_r != DEPTH[CW-1:0]);
  assign out_valid = (count_r != {CW{1'b0}});
  assign out_data = mem[rd_ptr_r];
  assign level = count_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function [AW-1:0] bump;
    input [AW-1:0] p;
    begin
      bump = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {CW{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= bump(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= bump(rd_ptr_r);
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // word_fifo
`default_nettype wire

/* include/meter_defines.vh */
// constants for the memory network credit meter
// What this block does
// - stall a send only if input sinks all
// - outgoing queue holds sixteen words
// - queue absorbs two-word read plus evict
// - store issue decrements store counter
// - store reply increments store counter
// - zero counter halts cache until reply
// - two counters, stall if either zero
// - borrow write decrements selected counter
// - ack code 1110, sender picks counter
// - line write: code 0100, address, eight words
`ifndef METER_DEFINES_VH
`define METER_DEFINES_VH
// register byte offsets
`define REG_STORE_ACK 4'h0
`define REG_CREDITS 4'h4
`define REG_STATUS 4'h8
`define REG_SEND 4'hC
// store-ack register fields
`define ACK_BORROW_BIT 0
`define ACK_PARTNER_BIT 1
// credit register fields
`define CRD_NP_LO 0
`define CRD_P_LO 16
// status register fields
`define STS_STATE_HI 1
`define STS_STALL_BIT 2
`define STS_DROP_BIT 3
`define STS_LEVEL_LO 8
// network header fields
`define HDR_LEN_HI 28
`define HDR_LEN_LO 24
`define HDR_USR_HI 23
`define HDR_USR_LO 20
`define HDR_SENDER_BIT 19
`define HDR_DEST_HI 18
// user-field codes
`define USR_LINE_READ 4'h0
`define USR_LINE_WRITE 4'h4
`define USR_STORE_ACK 4'hE
// message lengths after the header
`define LEN_READ 5'h01
`define LEN_WRITE 5'h09
`define LINE_WORDS 4'h8
// cache sender states
`define ST_IDLE 2'h0
`define ST_HDR 2'h1
`define ST_ADDR 2'h2
`define ST_DATA 2'h3
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif
